/* File: design/iad_pkg.sv */
// Constants, types and the opcode decoder shared by the instruction decoder block.
// Assumes a 14-bit instruction word and an 8-bit data path with 16-bit indirect pointers.
package iad_pkg;

  // ==========================================================================
  // Opcode patterns: an opcode matches when (word & mask) equals value.
  localparam logic [13:0] IAD_WDT_VAL       = 14'h0064;
  localparam logic [13:0] IAD_SLEEP_VAL     = 14'h0063;
  localparam logic [13:0] IAD_FULL_MASK     = 14'h3FFF;
  localparam logic [13:0] IAD_PINDIR_VAL    = 14'h0060;
  localparam logic [13:0] IAD_MM_MASK       = 14'h3FF8;
  localparam logic [13:0] IAD_LOAD_MM_VAL   = 14'h0010;
  localparam logic [13:0] IAD_STORE_MM_VAL  = 14'h0018;
  localparam logic [13:0] IAD_K6_MASK       = 14'h3F80;
  localparam logic [13:0] IAD_PTRADD_VAL    = 14'h3100;
  localparam logic [13:0] IAD_LOAD_IDX_VAL  = 14'h3F00;
  localparam logic [13:0] IAD_STORE_IDX_VAL = 14'h3F80;
  localparam logic [13:0] IAD_BYTE_MASK     = 14'h3F00;
  localparam logic [13:0] IAD_AND_LIT_VAL   = 14'h3900;
  localparam logic [13:0] IAD_ADD_LIT_VAL   = 14'h3E00;
  localparam logic [13:0] IAD_AND_FILE_VAL  = 14'h0500;
  localparam logic [13:0] IAD_ADD_FILE_VAL  = 14'h0700;

  // ==========================================================================
  // Field positions inside the instruction word, and the pointer MSB position.
  localparam int IAD_PSEL_K6_BIT = 6;
  localparam int IAD_PSEL_MM_BIT = 2;
  localparam int IAD_DEST_BIT    = 7;
  localparam int IAD_K6_SIGN_BIT = 5;
  localparam int IAD_PTR_MSB     = 15;

  // ==========================================================================
  // Reset values, fixed addresses and pointer step values.
  localparam logic [7:0]  IAD_RST_ACC     = 8'h00;
  localparam logic [15:0] IAD_RST_PTR     = 16'h0000;
  localparam logic [7:0]  IAD_RST_PIN_DIR = 8'hFF;
  localparam logic [6:0]  IAD_WINDOW0_IDX = 7'h00;
  localparam logic [6:0]  IAD_WINDOW1_IDX = 7'h01;
  localparam logic [15:0] IAD_PTR_INC     = 16'h0001;
  localparam logic [15:0] IAD_PTR_DEC     = 16'hFFFF;

  typedef enum logic [3:0] {
    OP_NONE, OP_WDT, OP_SLEEP, OP_PINDIR, OP_PTRADD, OP_LOAD_MM, OP_STORE_MM,
    OP_LOAD_IDX, OP_STORE_IDX, OP_AND_LIT, OP_ADD_LIT, OP_AND_FILE, OP_ADD_FILE
  } iad_op_type;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } iad_mem_wr_type;

  typedef struct packed {
    logic carry;
    logic nibble;
    logic null_f;
    logic expiry;
    logic powerdown;
  } iad_status_type;

  // The two fixed codes sit inside the pin direction pattern, so they are tested first.
  function automatic iad_op_type iad_decode(input logic [13:0] w);
    iad_op_type op;
    op = OP_NONE;
    if ((w & IAD_FULL_MASK) == IAD_WDT_VAL) op = OP_WDT;
    else if ((w & IAD_FULL_MASK) == IAD_SLEEP_VAL) op = OP_SLEEP;
    else if ((w & IAD_MM_MASK) == IAD_PINDIR_VAL) op = OP_PINDIR;
    else if ((w & IAD_MM_MASK) == IAD_LOAD_MM_VAL) op = OP_LOAD_MM;
    else if ((w & IAD_MM_MASK) == IAD_STORE_MM_VAL) op = OP_STORE_MM;
    else if ((w & IAD_K6_MASK) == IAD_PTRADD_VAL) op = OP_PTRADD;
    else if ((w & IAD_K6_MASK) == IAD_LOAD_IDX_VAL) op = OP_LOAD_IDX;
    else if ((w & IAD_K6_MASK) == IAD_STORE_IDX_VAL) op = OP_STORE_IDX;
    else if ((w & IAD_BYTE_MASK) == IAD_AND_LIT_VAL) op = OP_AND_LIT;
    else if ((w & IAD_BYTE_MASK) == IAD_ADD_LIT_VAL) op = OP_ADD_LIT;
    else if ((w & IAD_BYTE_MASK) == IAD_AND_FILE_VAL) op = OP_AND_FILE;
    else if ((w & IAD_BYTE_MASK) == IAD_ADD_FILE_VAL) op = OP_ADD_FILE;
    return op;
  endfunction

endpackage

/* File: design/iad_alu.sv */
// Byte AND and ADD unit with carry, nibble carry and zero results.
// Assumes purely combinational use inside the decoder; no state is held here.
`timescale 1ns/1ps
module iad_alu (
  input  wire logic [7:0] opnd_a,
  input  wire logic [7:0] opnd_b,
  input  wire logic       do_add,
  output logic      [7:0] result,
  output logic            carry_out,
  output logic            nibble_out,
  output logic            zero_out
);
  logic [8:0] sum;
  logic [4:0] low_sum;

  assign sum        = {1'b0, opnd_a} + {1'b0, opnd_b};
  assign low_sum    = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]};
  assign result     = do_add ? sum[7:0] : (opnd_a & opnd_b);
  assign carry_out  = sum[8];
  assign nibble_out = low_sum[4];
  assign zero_out   = (result == 8'h00);
endmodule

/* File: design/iad_decoder.sv */
// Decode and execute logic for inherent, indirect pointer and AND/ADD instructions.
// Assumes a data memory with asynchronous read (rd_data follows rd_addr in the same cycle).
// Functional notes
// - Branch or true test costs two cycles; second cycle is an idle operation.
// - Window access through a pointer with MSB set adds one cycle.
// - Decode watchdog clear and standby entry codes; both update expiry and powerdown.
// - Pin direction opcode copies accumulator into selected pin direction register.
// - Pointer add decoded with pointer select bit and 6-bit literal.
// - Pointer add adds sign-extended literal to 16-bit pointer; flags unchanged.
// - Pointer arithmetic wraps modulo 16 bits.
// - Indirect load with update mode moves window byte to accumulator; sets null flag.
// - Indexed indirect load reads pointer plus literal; sets null flag.
// - Indirect store with update mode writes accumulator; flags unchanged.
// - Indexed indirect store writes accumulator to pointer plus literal; flags unchanged.
// - AND literal into accumulator; only null flag changes.
// - Add literal into accumulator; carry, nibble and null flags change.
// - AND file register; destination bit selects accumulator or register; null flag.
// - Add file register; destination bit routes result; carry, nibble, null flags.
`timescale 1ns/1ps
module iad_decoder
  import iad_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  instr_valid,
  input  wire logic [13:0]           instr_word,
  input  wire logic                  branch_taken,
  output logic                       instr_ready,
  output logic                       idle_op_pulse,
  output logic [15:0]                rd_addr,
  input  wire logic [7:0]            rd_data,
  output iad_pkg::iad_mem_wr_type    mem_wr,
  output logic [7:0]                 acc_out,
  output iad_pkg::iad_status_type    status,
  output logic [1:0][15:0]           ptr_out,
  output logic [7:0][7:0]            pin_dir_out,
  output logic                       watchdog_clear_pulse,
  output logic                       standby_req_pulse
);
  import iad_pkg::*;

  // ==========================================================================
  // Sequencing state
  typedef enum logic [1:0] {ST_RUN, ST_EXTRA, ST_FILL} iad_state_type;

  iad_state_type    state_reg;
  logic             fill_pending_reg;
  logic [7:0]       acc_reg;
  iad_status_type   status_reg;
  logic [1:0][15:0] ptr_reg;
  logic [7:0][7:0]  pin_dir_reg;
  iad_mem_wr_type   mem_wr_reg;
  logic             wdt_pulse_reg;
  logic             sleep_pulse_reg;

  logic        take;
  iad_op_type  op;
  logic        psel;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_step;
  logic [15:0] ptr_stepped;
  logic [15:0] k6_ext;
  logic [15:0] ptr_indexed;
  logic [6:0]  file_idx;
  logic        file_window;
  logic        is_mm;
  logic        is_file;
  logic        is_add;
  logic        dest_file;
  logic        needs_extra;
  logic [15:0] eff_addr;
  logic [7:0]  alu_b;
  logic [7:0]  alu_res;
  logic        alu_carry;
  logic        alu_nibble;
  logic        alu_zero;

  // ==========================================================================
  // Decode and address generation
  assign instr_ready = (state_reg == ST_RUN);
  assign take        = instr_valid && instr_ready;
  assign op          = iad_decode(instr_word);
  assign is_mm       = (op == OP_LOAD_MM) || (op == OP_STORE_MM);
  assign is_file     = (op == OP_AND_FILE) || (op == OP_ADD_FILE);
  assign is_add      = (op == OP_ADD_LIT) || (op == OP_ADD_FILE);
  assign dest_file   = instr_word[IAD_DEST_BIT];
  assign file_idx    = instr_word[6:0];
  assign file_window = is_file && ((file_idx == IAD_WINDOW0_IDX) ||
                                   (file_idx == IAD_WINDOW1_IDX));

  assign psel     = is_mm ? instr_word[IAD_PSEL_MM_BIT] : instr_word[IAD_PSEL_K6_BIT];
  assign ptr_cur  = file_window ? ptr_reg[file_idx[0]] : ptr_reg[psel];
  // update mode, low bit picks decrement
  assign ptr_step = instr_word[0] ? IAD_PTR_DEC : IAD_PTR_INC;
  assign ptr_stepped = ptr_cur + ptr_step;
  assign k6_ext      = {{10{instr_word[IAD_K6_SIGN_BIT]}}, instr_word[5:0]};
  assign ptr_indexed = ptr_cur + k6_ext;

  // window access with pointer MSB set
  assign needs_extra = (is_mm || (op == OP_LOAD_IDX) || (op == OP_STORE_IDX) ||
                        file_window) && ptr_cur[IAD_PTR_MSB];

  // Pre-modes (high mode bit clear) use the updated pointer, post-modes the old one.
  always_comb begin
    eff_addr = 16'h0000;
    unique case (op)
      OP_LOAD_MM, OP_STORE_MM: eff_addr = instr_word[1] ? ptr_cur : ptr_stepped;
      OP_LOAD_IDX, OP_STORE_IDX: eff_addr = ptr_indexed;
      OP_AND_FILE, OP_ADD_FILE: eff_addr = file_window ? ptr_cur : {9'h000, file_idx};
      default: eff_addr = 16'h0000;
    endcase
  end

  assign rd_addr = eff_addr;
  assign alu_b   = is_file ? rd_data : instr_word[7:0];

  iad_alu u_alu (
    .opnd_a     (acc_reg),
    .opnd_b     (alu_b),
    .do_add     (is_add),
    .result     (alu_res),
    .carry_out  (alu_carry),
    .nibble_out (alu_nibble),
    .zero_out   (alu_zero)
  );

  // ==========================================================================
  // Cycle sequencing
  // idle fill after branch
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg        <= ST_RUN;
      fill_pending_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (take && needs_extra) begin
            state_reg        <= ST_EXTRA;
            fill_pending_reg <= branch_taken;
          end else if (take && branch_taken) begin
            state_reg <= ST_FILL;
          end
        end
        ST_EXTRA: begin
          state_reg        <= fill_pending_reg ? ST_FILL : ST_RUN;
          fill_pending_reg <= 1'b0;
        end
        ST_FILL: state_reg <= ST_RUN;
      endcase
    end
  end

  assign idle_op_pulse = (state_reg == ST_FILL);

  // ==========================================================================
  // Accumulator
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      acc_reg <= IAD_RST_ACC;
    end else if (take) begin
      unique case (op)
        OP_LOAD_MM, OP_LOAD_IDX: acc_reg <= rd_data;
        OP_AND_LIT, OP_ADD_LIT: acc_reg <= alu_res;
        OP_AND_FILE, OP_ADD_FILE: if (!dest_file) acc_reg <= alu_res;
        default: acc_reg <= acc_reg;
      endcase
    end
  end

  // ==========================================================================
  // Status flags
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_reg <= '{carry: 1'b0, nibble: 1'b0, null_f: 1'b0, expiry: 1'b1, powerdown: 1'b1};
    end else if (take) begin
      unique case (op)
        OP_WDT: begin
          status_reg.expiry    <= 1'b1;
          status_reg.powerdown <= 1'b1;
        end
        OP_SLEEP: begin
          status_reg.expiry    <= 1'b1;
          status_reg.powerdown <= 1'b0;
        end
        OP_LOAD_MM, OP_LOAD_IDX: status_reg.null_f <= (rd_data == 8'h00);
        OP_AND_LIT, OP_AND_FILE: status_reg.null_f <= alu_zero;
        OP_ADD_LIT, OP_ADD_FILE: begin
          status_reg.carry  <= alu_carry;
          status_reg.nibble <= alu_nibble;
          status_reg.null_f <= alu_zero;
        end
        default: status_reg <= status_reg;
      endcase
    end
  end

  // ==========================================================================
  // Indirect pointers
  for (genvar n = 0; n < 2; n++) begin : g_ptr
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        ptr_reg[n] <= IAD_RST_PTR;
      end else if (take && (op == OP_PTRADD) && (psel == 1'(n))) begin
        ptr_reg[n] <= ptr_indexed;
      end else if (take && is_mm && (psel == 1'(n))) begin
        ptr_reg[n] <= ptr_stepped;
      end
    end
  end

  // ==========================================================================
  // Pin direction registers
  // copy accumulator to pin direction
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_dir_reg <= {8{IAD_RST_PIN_DIR}};
    end else if (take && (op == OP_PINDIR)) begin
      pin_dir_reg[instr_word[2:0]] <= acc_reg;
    end
  end

  // ==========================================================================
  // Data memory writes and core side pulses
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mem_wr_reg <= '0;
    end else begin
      mem_wr_reg.en <= 1'b0;
      if (take && ((op == OP_STORE_MM) || (op == OP_STORE_IDX))) begin
        mem_wr_reg <= '{en: 1'b1, addr: eff_addr, data: acc_reg};
      end else if (take && is_file && dest_file) begin
        mem_wr_reg <= '{en: 1'b1, addr: eff_addr, data: alu_res};
      end
    end
  end

  // The pulses tell the watchdog and power hardware outside; they are not held here.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wdt_pulse_reg   <= 1'b0;
      sleep_pulse_reg <= 1'b0;
    end else begin
      wdt_pulse_reg   <= take && (op == OP_WDT);
      sleep_pulse_reg <= take && (op == OP_SLEEP);
    end
  end

  assign mem_wr               = mem_wr_reg;
  assign acc_out              = acc_reg;
  assign status               = status_reg;
  assign ptr_out              = ptr_reg;
  assign pin_dir_out          = pin_dir_reg;
  assign watchdog_clear_pulse = wdt_pulse_reg;
  assign standby_req_pulse    = sleep_pulse_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_fill_then_run;
    idle_op_pulse && !instr_ready ##1 instr_ready;
  endsequence

  property p_fill;
    take && branch_taken && !needs_extra |=> s_fill_then_run;
  endproperty
  a_fill: assert property (p_fill) else $error("Idle fill cycle missing.");

  property p_extra;
    take && needs_extra |=> !instr_ready && !idle_op_pulse ##1 (instr_ready || idle_op_pulse);
  endproperty
  a_extra: assert property (p_extra) else $error("Extra cycle wrong.");

  property p_wdt;
    take && (op == OP_WDT) |=> status.expiry && status.powerdown && watchdog_clear_pulse;
  endproperty
  a_wdt: assert property (p_wdt) else $error("Watchdog clear flags wrong.");

  property p_pindir;
    take && (op == OP_PINDIR) |=> pin_dir_out[$past(instr_word[2:0])] == $past(acc_reg);
  endproperty
  a_pindir: assert property (p_pindir) else $error("Pin direction not loaded.");

  property p_ptradd;
    take && (op == OP_PTRADD) |=>
      (ptr_out[$past(psel)] == $past(ptr_cur) + $past(k6_ext)) && $stable(status);
  endproperty
  a_ptradd: assert property (p_ptradd) else $error("Pointer add wrong.");

  property p_and_literal_op;
    take && (op == OP_AND_LIT) |=> (acc_out == ($past(acc_reg) & $past(instr_word[7:0])))
      && (status.null_f == (acc_out == 8'h00)) && $stable(status.carry);
  endproperty
  a_and_literal_op: assert property (p_and_literal_op) else $error("Literal AND wrong.");

  property p_sum_literal_op;
    take && (op == OP_ADD_LIT) |=>
      {status.carry, acc_out} == {1'b0, $past(acc_reg)} + {1'b0, $past(instr_word[7:0])};
  endproperty
  a_sum_literal_op: assert property (p_sum_literal_op) else $error("Literal add wrong.");

  property p_store;
    take && (op == OP_STORE_IDX) |=> mem_wr.en && (mem_wr.data == $past(acc_reg))
      && (mem_wr.addr == $past(ptr_indexed)) && $stable(status);
  endproperty
  a_store: assert property (p_store) else $error("Indexed store wrong.");

  property p_load;
    take && (op == OP_LOAD_MM) |=> (acc_out == $past(rd_data)) && !mem_wr.en
      && (status.null_f == ($past(rd_data) == 8'h00));
  endproperty
  a_load: assert property (p_load) else $error("Indirect load wrong.");

endmodule

/* File: testbench/inherent_indirect_arith_decoder_tb.sv */
// Self-checking testbench for the instruction decoder block.
// Assumes the decoder package and modules are compiled first; the bench models memory itself.
`timescale 1ns/1ps
module inherent_indirect_arith_decoder_tb;
  import iad_pkg::*;

  // ==========================================================================
  // Signals and bench state
  logic                 clk_sys;
  logic                 reset_n;
  logic                 instr_valid;
  logic [13:0]          instr_word;
  logic                 branch_taken;
  logic                 instr_ready;
  logic                 idle_op_pulse;
  logic [15:0]          rd_addr;
  logic [7:0]           rd_data;
  iad_mem_wr_type       mem_wr;
  logic [7:0]           acc_out;
  iad_status_type       status;
  logic [1:0][15:0]     ptr_out;
  logic [7:0][7:0]      pin_dir_out;
  logic                 watchdog_clear_pulse;
  logic                 standby_req_pulse;
  int                   err_total;
  int                   total_checks;
  logic [7:0]           acc_m;
  logic [4:0]           st_m;
  logic [1:0][15:0]     ptr_m;

  // Memory reads back a value derived from the address, so a wrong address shows as wrong data.
  assign rd_data = rd_addr[7:0] + 8'h10;

  iad_decoder dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .branch_taken(branch_taken), .instr_ready(instr_ready),
    .idle_op_pulse(idle_op_pulse), .rd_addr(rd_addr), .rd_data(rd_data), .mem_wr(mem_wr),
    .acc_out(acc_out), .status(status), .ptr_out(ptr_out), .pin_dir_out(pin_dir_out),
    .watchdog_clear_pulse(watchdog_clear_pulse), .standby_req_pulse(standby_req_pulse)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // Returns 2 ns after the taking edge, when registered results have landed.
  task automatic run_op(input logic [13:0] w, input logic br);
    int n;
    n = 0;
    // A clock edge between two requests keeps valid from being lowered and raised at once.
    @(posedge clk_sys);
    #2;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    instr_valid = 1'b1;
    instr_word = w;
    branch_taken = br;
    @(posedge clk_sys);
    #2;
    instr_valid = 1'b0;
    branch_taken = 1'b0;
  endtask

  task automatic model_alu(input logic [7:0] b, input logic is_add, output logic [7:0] r);
    logic [8:0] s;
    s = {1'b0, acc_m} + {1'b0, b};
    if (is_add) begin
      r = s[7:0];
      st_m[4] = s[8];
      st_m[3] = ({1'b0, acc_m[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
    end else begin
      r = acc_m & b;
    end
    st_m[2] = (r == 8'h00);
  endtask

  task automatic do_lit(input logic is_add, input logic [7:0] k);
    logic [7:0] r;
    model_alu(k, is_add, r);
    acc_m = r;
    run_op((is_add ? IAD_ADD_LIT_VAL : IAD_AND_LIT_VAL) | {6'h00, k}, 1'b0);
    chk(acc_out, acc_m);
    chk(status, st_m);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 8; i++) chk(pin_dir_out[i], 8'hFF);
    chk(acc_out, 8'h00);
    chk(ptr_out, 32'h0000_0000);
    chk(status, 5'h03);
  endtask

  task automatic t_inherent();
    run_op(IAD_SLEEP_VAL, 1'b0);
    chk({standby_req_pulse, watchdog_clear_pulse}, 2'h2);
    chk(status, 5'h02);
    @(posedge clk_sys);
    #2;
    chk(standby_req_pulse, 1'b0);
    run_op(IAD_WDT_VAL, 1'b0);
    chk({standby_req_pulse, watchdog_clear_pulse}, 2'h1);
    chk(status, 5'h03);
  endtask

  task automatic t_ptr_add(input int n, input logic [5:0] k);
    ptr_m[n] = ptr_m[n] + {{10{k[5]}}, k};
    run_op(IAD_PTRADD_VAL | {7'h00, n[0], k}, 1'b0);
    chk(ptr_out[n], ptr_m[n]);
    chk(status, st_m);
  endtask

  task automatic t_pindir();
    run_op(IAD_PINDIR_VAL | 14'h0005, 1'b0);
    for (int i = 0; i < 8; i++) chk(pin_dir_out[i], (i == 5) ? acc_m : 8'hFF);
  endtask

  // Pointer 1 sits below the window threshold, so no extra cycle is due.
  task automatic t_mm(input logic store, input logic [1:0] mm);
    logic [15:0] nxt;
    logic [15:0] a;
    nxt = ptr_m[1] + (mm[0] ? 16'hFFFF : 16'h0001);
    a = mm[1] ? ptr_m[1] : nxt;
    ptr_m[1] = nxt;
    if (!store) begin
      acc_m = a[7:0] + 8'h10;
      st_m[2] = (acc_m == 8'h00);
    end
    run_op((store ? IAD_STORE_MM_VAL : IAD_LOAD_MM_VAL) | {11'h000, 1'b1, mm}, 1'b0);
    chk(ptr_out[1], ptr_m[1]);
    chk(acc_out, acc_m);
    chk(status, st_m);
    chk({mem_wr.en, mem_wr.addr, mem_wr.data}, store ? {1'b1, a, acc_m} : 25'h0);
    chk(instr_ready, 1'b1);
  endtask

  task automatic t_indexed();
    logic [15:0] a;
    acc_m = 8'h00;
    st_m[2] = 1'b1;
    run_op(IAD_LOAD_IDX_VAL | 14'h0010, 1'b1);
    chk(acc_out, acc_m);
    chk(status, st_m);
    chk(ptr_out, ptr_m);
    chk({instr_ready, idle_op_pulse}, 2'h0);
    @(posedge clk_sys);
    #2;
    chk({instr_ready, idle_op_pulse}, 2'h1);
    @(posedge clk_sys);
    #2;
    chk({instr_ready, idle_op_pulse}, 2'h2);
    do_lit(1'b1, 8'h35);
    a = ptr_m[1] + 16'hFFFE;
    run_op(IAD_STORE_IDX_VAL | 14'h007E, 1'b0);
    chk({mem_wr.en, mem_wr.addr, mem_wr.data}, {1'b1, a, acc_m});
    chk(status, st_m);
    chk(ptr_out, ptr_m);
    chk(instr_ready, 1'b1);
    run_op(IAD_AND_LIT_VAL | 14'h00FF, 1'b1);
    chk({instr_ready, idle_op_pulse, acc_out}, {2'h1, acc_m});
    @(posedge clk_sys);
    #2;
    chk({instr_ready, idle_op_pulse}, 2'h2);
  endtask

  task automatic t_file(input logic is_add, input logic d);
    logic [7:0] r;
    model_alu(8'h30, is_add, r);
    if (!d) acc_m = r;
    run_op((is_add ? IAD_ADD_FILE_VAL : IAD_AND_FILE_VAL) | {6'h00, d, 7'h20}, 1'b0);
    chk(mem_wr.en, d);
    if (d) chk({mem_wr.addr, mem_wr.data}, {16'h0020, r});
    chk(acc_out, acc_m);
    chk(status, st_m);
  endtask

  task automatic t_window();
    logic [7:0] r;
    model_alu(ptr_m[0][7:0] + 8'h10, 1'b1, r);
    acc_m = r;
    run_op(IAD_ADD_FILE_VAL | {7'h00, IAD_WINDOW0_IDX}, 1'b0);
    chk({mem_wr.en, acc_out}, {1'b0, acc_m});
    chk(status, st_m);
    chk(ptr_out, ptr_m);
    chk({instr_ready, idle_op_pulse}, 2'h0);
    @(posedge clk_sys);
    #2;
    chk({instr_ready, idle_op_pulse}, 2'h2);
  endtask

  // ==========================================================================
  // Closing and main sequence
  task automatic complete_run();
    $display("err_total=%0d total_checks=%0d", err_total, total_checks);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #40000;
    err_total++;
    complete_run();
  end

  initial begin
    err_total = 0;
    total_checks = 0;
    reset_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    branch_taken = 1'b0;
    acc_m = 8'h00;
    st_m = 5'h03;
    ptr_m = '0;
    repeat (5) @(posedge clk_sys);
    #2;
    reset_n = 1'b1;
    t_reset();
    t_inherent();
    do_lit(1'b1, 8'hF8);
    do_lit(1'b1, 8'h08);
    do_lit(1'b1, 8'h0F);
    do_lit(1'b0, 8'hF0);
    do_lit(1'b1, 8'h0F);
    do_lit(1'b0, 8'h3C);
    t_pindir();
    t_ptr_add(1, 6'h3F);
    t_ptr_add(1, 6'h1F);
    t_ptr_add(0, 6'h20);
    for (int i = 0; i < 8; i++) t_mm(i[2], i[1:0]);
    t_indexed();
    t_file(1'b1, 1'b1);
    t_file(1'b0, 1'b0);
    t_file(1'b1, 1'b0);
    t_file(1'b0, 1'b1);
    t_window();
    complete_run();
  end
endmodule
